// ---- fosr_host_model.sv ----
`timescale 1ns/1ps
// ====
// host side of the memory bus
module fosr_host_model (
  input wire logic clock,
  output logic [7:0] primary_sector_selects,
  output logic [3:0] secondary_sector_selects,
  output logic mem_read_strobe,
  output logic mem_write_strobe,
  output logic mem_addr0,
  output logic [7:0] mem_write_byte,
  input wire logic [15:0] mem_data_out,
  input wire logic mem_data_oe
);
  initial begin
    {primary_sector_selects, secondary_sector_selects} = '0;
    mem_read_strobe = 1'b0;
    mem_write_strobe = 1'b0;
    mem_addr0 = 1'b0;
    mem_write_byte = 8'h00;
  end
  // ====
  // bus cycles, long enough for the pin synchronisers
  task automatic rd(input logic [11:0] sel, output logic [15:0] d, output logic oe);
    @(posedge clock);
    {primary_sector_selects, secondary_sector_selects} <= sel;
    mem_read_strobe <= 1'b1;
    repeat (6) @(posedge clock);
    d = mem_data_out;
    oe = mem_data_oe;
    {primary_sector_selects, secondary_sector_selects} <= '0;
    mem_read_strobe <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic hold(input logic [11:0] sel);
    @(posedge clock);
    {primary_sector_selects, secondary_sector_selects} <= sel;
    repeat (3) @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] sel, input logic [7:0] b);
    @(posedge clock);
    {primary_sector_selects, secondary_sector_selects} <= sel;
    mem_write_byte <= b;
    mem_write_strobe <= 1'b1;
    repeat (5) @(posedge clock);
    {primary_sector_selects, secondary_sector_selects} <= '0;
    mem_write_strobe <= 1'b0;
    // released lines must not keep the old byte
    mem_write_byte <= ~b;
    repeat (4) @(posedge clock);
  endtask
endmodule

// ---- fosr_pin_sync.sv ----
`timescale 1ns/1ps
module fosr_pin_sync
  import fosr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  fosr_sync_if.sync pins
);
  // =====================================================
  // two-stage pin synchroniser
  typedef struct packed {
    logic [13:0] s1;
    logic [13:0] s2;
  } fosr_sync_t;
  fosr_sync_t q;
  fosr_sync_t next_q;

  always_comb begin
    next_q = q;
    next_q.s1 = {pins.raw_primary, pins.raw_secondary, pins.raw_read, pins.raw_write};
    next_q.s2 = q.s1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign {pins.primary, pins.secondary, pins.read, pins.write} = q.s2;
endmodule

// ---- fosr_pkg.sv ----
package fosr_pkg;
  // =====================================================
  // avalon register map (word index * 4 = byte address)
  localparam logic [3:0] FOSR_ADDR_CTRL = 4'h0;
  localparam logic [3:0] FOSR_ADDR_STATUS = 4'h1;
  localparam logic [3:0] FOSR_ADDR_PROT = 4'h2;
  localparam logic [3:0] FOSR_ADDR_EVENT = 4'h3;
  localparam logic [3:0] FOSR_ADDR_LAST = 4'h4;
  // ctrl fields
  localparam int FOSR_CTRL_LANE_BIT = 0;
  localparam logic [31:0] FOSR_CTRL_RESET = 32'h0000_0000;
  // event register commands (written by the embedded algorithm sequencer)
  localparam int FOSR_EV_PROG_BIT = 0;
  localparam int FOSR_EV_ERASE_BIT = 1;
  localparam int FOSR_EV_MORE_BIT = 2;
  localparam int FOSR_EV_DONE_BIT = 3;
  localparam int FOSR_EV_FAIL_BIT = 4;
  localparam int FOSR_EV_RESET_BIT = 5;
  localparam int FOSR_EV_DATA7_BIT = 8;
  // status byte positions
  localparam int FOSR_POLL_POS = 7;
  localparam int FOSR_TOGGLE_POS = 6;
  localparam int FOSR_FAIL_POS = 5;
  localparam int FOSR_WINDOW_POS = 3;
  localparam logic [7:0] FOSR_PROTECTED = 8'h01;
  localparam logic [7:0] FOSR_UNPROTECTED = 8'h00;
  localparam logic [7:0] FOSR_RESET_CMD = 8'hF0;
  // timing
  localparam int FOSR_CLOCK_HZ = 20_000_000;
  localparam int FOSR_WINDOW_US = 100;
  localparam int FOSR_WINDOW_CYCLES = FOSR_WINDOW_US * (FOSR_CLOCK_HZ / 1_000_000);
  localparam int FOSR_BLOCKED_US = 100;
  localparam int FOSR_BLOCKED_CYCLES = FOSR_BLOCKED_US * (FOSR_CLOCK_HZ / 1_000_000);
  localparam int FOSR_PROG_PULSES = 4;
  localparam int FOSR_ERASE_PULSES = 6;
  localparam int FOSR_QUERY_WRITES = 3;

  typedef enum logic [2:0] {
    FOSR_IDLE = 3'b000,
    FOSR_PROG = 3'b001,
    FOSR_ERASE = 3'b010,
    FOSR_BLOCKED = 3'b011,
    FOSR_QUERY = 3'b100
  } fosr_mode_t;
endpackage

// ---- fosr_sync_if.sv ----
`timescale 1ns/1ps
interface fosr_sync_if;
  logic [7:0] raw_primary;
  logic [3:0] raw_secondary;
  logic raw_read;
  logic raw_write;
  logic [7:0] primary;
  logic [3:0] secondary;
  logic read;
  logic write;
  modport core (output raw_primary, output raw_secondary, output raw_read, output raw_write,
    input primary, input secondary, input read, input write);
  modport sync (input raw_primary, input raw_secondary, input raw_read, input raw_write,
    output primary, output secondary, output read, output write);
endinterface

// ---- fosr_tb_top.sv ----
`timescale 1ns/1ps
// ====
// self-checking bench
module fosr_tb_top;
  import fosr_pkg::*;
  localparam int WC = 20;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, r;
  logic avs_waitrequest, rs, ws, a0, oe, up;
  logic [7:0] ps, wb;
  logic [7:0] array_byte = 8'h00;
  logic [7:0] masks = 8'h00;
  logic [3:0] ss;
  logic [11:0] prot = 12'h000;
  logic [15:0] dout, d, d2;
  logic [31:0] rng = 32'h709f_ea37;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int k, idx;
  always #25 clock = ~clock;
  fosr_top #(.WINDOW_CYCLES(WC), .BLOCKED_CYCLES(WC)) dut (.clock(clock), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .primary_sector_selects(ps), .secondary_sector_selects(ss), .mem_read_strobe(rs),
    .mem_write_strobe(ws), .mem_addr0(a0), .mem_write_byte(wb), .array_byte(array_byte),
    .sector_protected(prot), .old_word_bit7_masks(masks), .mem_data_out(dout), .mem_data_oe(oe));
  fosr_host_model host (.clock(clock), .primary_sector_selects(ps), .secondary_sector_selects(ss),
    .mem_read_strobe(rs), .mem_write_strobe(ws), .mem_addr0(a0), .mem_write_byte(wb),
    .mem_data_out(dout), .mem_data_oe(oe));
  // ====
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [15:0] lane(input logic [7:0] b, input logic u);
    return u ? {b, 8'h00} : {8'h00, b};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic ev(input int b, input logic d7);
    av(1'b1, FOSR_ADDR_EVENT, (32'h0000_0001 << b) | ({31'h0000_0000, d7} << FOSR_EV_DATA7_BIT), r);
  endtask
  task automatic done_reset;
    ev(FOSR_EV_DONE_BIT, 1'b0);
    host.wr(12'h010, FOSR_RESET_CMD);
  endtask
  task automatic finish_test;
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      finish_test();
    end
  end
  // ====
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    av(1'b0, FOSR_ADDR_CTRL, 32'h0000_0000, r);
    chk("ctrl reset", FOSR_CTRL_RESET, r);
    av(1'b1, FOSR_ADDR_LAST, 32'hFFFF_FFFF, r);
    av(1'b0, FOSR_ADDR_LAST, 32'h0000_0000, r);
    chk("unmapped", 32'h0000_0000, r);
    for (k = 0; k < 2; k++) begin
      up = k[0];
      av(1'b1, FOSR_ADDR_CTRL, {31'h0000_0000, up}, r);
      rng = xs(rng);
      array_byte <= rng[7:0];
      ev(FOSR_EV_PROG_BIT, rng[8]);
      av(1'b0, FOSR_ADDR_EVENT, 32'h0000_0000, r);
      chk("mode", 32'(FOSR_PROG), r);
      host.rd(12'h010, d, oe);
      host.rd(12'h010, d2, oe);
      chk("poll", lane({~rng[8], 7'h00}, up), d & ~lane(8'h48, up));
      chk("toggle", lane(8'h40, up), (d ^ d2) & lane(8'h40, up));
      host.rd(12'h000, d, oe);
      chk("unselected oe", 32'h0000_0000, {31'h0000_0000, oe});
      ev(FOSR_EV_DONE_BIT, 1'b0);
      host.rd(12'h010, d, oe);
      host.rd(12'h010, d2, oe);
      chk("array", lane(array_byte, up), d);
      chk("stopped", d, d2);
      ev(FOSR_EV_ERASE_BIT, 1'b0);
      host.rd(12'h010, d, oe);
      chk("erase", 32'h0000_0000, d & ~lane(8'h40, up));
      repeat (WC * 2) @(posedge clock);
      host.rd(12'h010, d, oe);
      chk("window end", lane(8'h08, up), d & ~lane(8'h40, up));
      done_reset();
      ev(FOSR_EV_ERASE_BIT, 1'b0);
      ev(FOSR_EV_MORE_BIT, 1'b0);
      host.rd(12'h010, d, oe);
      chk("window more", lane(8'h08, up), d & ~lane(8'h40, up));
      done_reset();
      masks <= up ? 8'h00 : 8'hFF;
      ev(FOSR_EV_PROG_BIT, 1'b1);
      if (up) begin
        ev(FOSR_EV_FAIL_BIT, 1'b0);
      end
      host.rd(12'h010, d, oe);
      chk("fail set", lane(8'h20, up), d & ~lane(8'h48, up));
      ev(FOSR_EV_DONE_BIT, 1'b0);
      av(1'b0, FOSR_ADDR_STATUS, 32'h0000_0000, r);
      chk("fail held", 32'h0000_0020, r & 32'h0000_0020);
      host.wr(12'h010, FOSR_RESET_CMD);
      masks <= 8'h00;
      host.rd(12'h010, d, oe);
      chk("fail cleared", lane(array_byte, up), d);
      av(1'b0, FOSR_ADDR_STATUS, 32'h0000_0000, r);
      chk("fail clear reg", 32'h0000_0000, r & 32'h0000_0020);
      prot <= 12'hFFF;
      host.hold(12'h010);
      ev(FOSR_EV_ERASE_BIT, 1'b0);
      av(1'b0, FOSR_ADDR_EVENT, 32'h0000_0000, r);
      chk("blocked mode", 32'(FOSR_BLOCKED), r);
      host.rd(12'h010, d, oe);
      chk("blocked", 32'h0000_0000, d & ~lane(8'h40, up));
      repeat (WC * 2) @(posedge clock);
      av(1'b0, FOSR_ADDR_EVENT, 32'h0000_0000, r);
      chk("blocked end", 32'(FOSR_IDLE), r);
      host.hold(12'h010);
      ev(FOSR_EV_PROG_BIT, 1'b1);
      av(1'b0, FOSR_ADDR_EVENT, 32'h0000_0000, r);
      chk("protected prog", 32'(FOSR_IDLE), r);
      host.hold(12'h000);
      rng = xs(rng);
      prot <= rng[11:0];
      idx = rng[19:16] % 12;
      repeat (3) host.wr(12'h001 << idx, 8'h90);
      host.rd(12'h001 << idx, d, oe);
      chk("query", lane({7'h00, prot[idx]}, up), d);
      av(1'b0, FOSR_ADDR_PROT, 32'h0000_0000, r);
      chk("prot reg", {20'h0_0000, prot}, r);
      host.wr(12'h001 << idx, FOSR_RESET_CMD);
    end
    finish_test();
  end
endmodule

// ---- fosr_top.sv ----
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module fosr_top
  import fosr_pkg::*;
#(
  parameter int WINDOW_CYCLES = FOSR_WINDOW_CYCLES,
  parameter int BLOCKED_CYCLES = FOSR_BLOCKED_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] primary_sector_selects,
  input wire logic [3:0] secondary_sector_selects,
  input wire logic mem_read_strobe,
  input wire logic mem_write_strobe,
  input wire logic mem_addr0,
  input wire logic [7:0] mem_write_byte,
  input wire logic [7:0] array_byte,
  input wire logic [11:0] sector_protected,
  input wire logic [7:0] old_word_bit7_masks,
  output logic [15:0] mem_data_out,
  output logic mem_data_oe
);
  // =====================================================
  // elaboration checks
  if (WINDOW_CYCLES < 2 || BLOCKED_CYCLES < 2) begin : g_bad
    $error("timing counts too small");
  end

  // =====================================================
  // state
  typedef struct packed {
    fosr_mode_t mode;
    logic [2:0] pulses;
    logic busy_valid;
    logic toggle;
    logic fail;
    logic window_open;
    logic erase_started;
    logic [31:0] window_cnt;
    logic [31:0] blocked_cnt;
    logic [31:0] window_age;
    logic data7;
    logic upper_lane;
    logic read_d;
    logic write_d;
    logic [1:0] query_writes;
    logic [15:0] data_out;
    logic data_oe;
    logic ack;
    logic [31:0] rdata;
  } fosr_state_t;
  fosr_state_t q;
  fosr_state_t next_q;

  fosr_sync_if pins ();
  assign pins.raw_primary = primary_sector_selects;
  assign pins.raw_secondary = secondary_sector_selects;
  assign pins.raw_read = mem_read_strobe;
  assign pins.raw_write = mem_write_strobe;

  fosr_pin_sync u_sync (
    .clock(clock),
    .rst(rst),
    .pins(pins)
  );

  logic selected;
  logic read_edge;
  logic write_edge;
  logic avs_wr;
  logic [7:0] status;
  logic sel_protected;
  logic [11:0] sel_vec;
  logic [7:0] byte_out;
  logic busy;

  assign sel_vec = {pins.primary, pins.secondary};
  assign selected = |sel_vec;
  assign read_edge = pins.read && !q.read_d && selected;
  assign write_edge = pins.write && !q.write_d && selected;
  // write lands on the edge where waitrequest is seen low
  assign avs_wr = avs_write && q.ack;
  assign sel_protected = |(sel_vec & sector_protected);
  assign busy = (q.mode == FOSR_PROG) || (q.mode == FOSR_ERASE) || (q.mode == FOSR_BLOCKED);

  // =====================================================
  // status byte assembly
  always_comb begin
    status = 8'h00;
    status[FOSR_POLL_POS] = (q.mode == FOSR_PROG) ? ~q.data7 : 1'b0;
    status[FOSR_TOGGLE_POS] = q.toggle;
    status[FOSR_FAIL_POS] = q.fail;
    status[FOSR_WINDOW_POS] = !q.window_open;
  end

  always_comb begin
    if (q.mode == FOSR_QUERY) begin
      byte_out = sel_protected ? FOSR_PROTECTED : FOSR_UNPROTECTED;
    end else if (busy && q.busy_valid) begin
      byte_out = status;
    end else begin
      byte_out = array_byte;
    end
  end

  // =====================================================
  // next state
  always_comb begin
    next_q = q;
    next_q.read_d = pins.read;
    next_q.write_d = pins.write;
    next_q.ack = (avs_read || avs_write) && !q.ack;
    next_q.data_oe = pins.read && selected;
    // age of the open window, only for the bound check
    next_q.window_age = q.window_open ? q.window_age + 32'd1 : 32'd0;
    // even address only; the status byte is not destructive to read
    if (read_edge && !mem_addr0) begin
      next_q.data_out = q.upper_lane ? {byte_out, 8'h00} : {8'h00, byte_out};
      if (busy && q.busy_valid) begin
        next_q.toggle = ~q.toggle;
      end
    end
    // bus registers
    if (avs_wr && avs_address == FOSR_ADDR_CTRL) begin
      next_q.upper_lane = avs_writedata[FOSR_CTRL_LANE_BIT];
    end
    if (avs_wr && avs_address == FOSR_ADDR_EVENT) begin
      if (avs_writedata[FOSR_EV_PROG_BIT]) begin
        if (sel_protected) begin
          next_q.mode = FOSR_IDLE;
        end else begin
          next_q.mode = FOSR_PROG;
          next_q.data7 = avs_writedata[FOSR_EV_DATA7_BIT];
          next_q.busy_valid = 1'b1;
          if ((old_word_bit7_masks & {8{avs_writedata[FOSR_EV_DATA7_BIT]}}) != 8'h00) begin
            next_q.fail = 1'b1;
          end
        end
      end
      if (avs_writedata[FOSR_EV_ERASE_BIT]) begin
        next_q.busy_valid = 1'b1;
        next_q.window_open = 1'b1;
        next_q.window_cnt = 32'(WINDOW_CYCLES);
        next_q.window_age = 32'd0;
        if (sel_protected) begin
          next_q.mode = FOSR_BLOCKED;
          next_q.blocked_cnt = 32'(BLOCKED_CYCLES);
        end else begin
          next_q.mode = FOSR_ERASE;
        end
      end
      if (avs_writedata[FOSR_EV_MORE_BIT]) begin
        next_q.window_open = 1'b0;
      end
      if (avs_writedata[FOSR_EV_DONE_BIT] && q.mode != FOSR_BLOCKED) begin
        next_q.mode = FOSR_IDLE;
      end
      if (avs_writedata[FOSR_EV_FAIL_BIT]) begin
        next_q.fail = 1'b1;
      end
    end
    // window timer; 100 us plus up to 20 %, we take the nominal edge
    if (q.window_open) begin
      if (q.window_cnt <= 32'd1) begin
        next_q.window_open = 1'b0;
      end else begin
        next_q.window_cnt = q.window_cnt - 32'd1;
      end
    end
    if (q.mode == FOSR_BLOCKED) begin
      if (q.blocked_cnt <= 32'd1) begin
        next_q.mode = FOSR_IDLE;
      end else begin
        next_q.blocked_cnt = q.blocked_cnt - 32'd1;
      end
    end
    // host instruction writes on the memory pins
    if (write_edge) begin
      if (mem_write_byte == FOSR_RESET_CMD) begin
        // fail is set-wins only against a same-cycle failure event; a same-cycle prog mask failure is cleared
        if (!(avs_wr && avs_address == FOSR_ADDR_EVENT && avs_writedata[FOSR_EV_FAIL_BIT])) begin
          next_q.fail = 1'b0;
        end
        if (!busy) begin
          next_q.mode = FOSR_IDLE;
        end
        next_q.query_writes = 2'd0;
      end else if (!busy) begin
        if (q.query_writes == 2'(FOSR_QUERY_WRITES - 1)) begin
          next_q.mode = FOSR_QUERY;
          next_q.query_writes = 2'd0;
        end else begin
          next_q.query_writes = q.query_writes + 2'd1;
        end
      end
    end
    if (next_q.mode == FOSR_IDLE) begin
      next_q.busy_valid = 1'b0;
    end
    // avalon read data
    next_q.rdata = 32'h0000_0000;
    unique case (avs_address)
      FOSR_ADDR_CTRL: next_q.rdata[FOSR_CTRL_LANE_BIT] = q.upper_lane;
      FOSR_ADDR_STATUS: next_q.rdata[7:0] = status;
      FOSR_ADDR_PROT: next_q.rdata[11:0] = sector_protected;
      FOSR_ADDR_EVENT: next_q.rdata[2:0] = q.mode;
      default: next_q.rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !q.ack;
  assign mem_data_out = q.data_out;
  assign mem_data_oe = q.data_oe;

  // =====================================================
  // checks
  property p_toggle_busy;
    @(posedge clock) disable iff (rst)
      (read_edge && !mem_addr0 && busy && q.busy_valid) |=> (q.toggle != $past(q.toggle));
  endproperty
  a_toggle_busy: assert property (p_toggle_busy) else $error("toggle did not invert");

  property p_toggle_idle;
    @(posedge clock) disable iff (rst)
      (q.mode == FOSR_IDLE && next_q.mode == FOSR_IDLE) |=> $stable(q.toggle);
  endproperty
  a_toggle_idle: assert property (p_toggle_idle) else $error("toggle moved while idle");

  property p_erase_poll;
    @(posedge clock) disable iff (rst)
      (q.mode == FOSR_ERASE) |-> (status[FOSR_POLL_POS] == 1'b0);
  endproperty
  a_erase_poll: assert property (p_erase_poll) else $error("poll not zero in erase");

  property p_prog_poll;
    @(posedge clock) disable iff (rst)
      (q.mode == FOSR_PROG) |-> (status[FOSR_POLL_POS] == ~q.data7);
  endproperty
  a_prog_poll: assert property (p_prog_poll) else $error("poll not complement");

  property p_fail_hold;
    @(posedge clock) disable iff (rst)
      (q.fail && !(write_edge && mem_write_byte == FOSR_RESET_CMD)) |=> q.fail;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail cleared without reset");

  property p_query_answer;
    @(posedge clock) disable iff (rst)
      (q.mode == FOSR_QUERY && read_edge && !mem_addr0 && !q.upper_lane)
        |=> (q.data_out[7:0] == {7'd0, $past(sel_protected)});
  endproperty
  a_query_answer: assert property (p_query_answer) else $error("bad protection answer");

  property p_window_bound;
    @(posedge clock) disable iff (rst)
      q.window_open |-> (q.window_age < 32'(WINDOW_CYCLES));
  endproperty
  a_window_bound: assert property (p_window_bound) else $error("window never closed");

  property p_blocked_end;
    @(posedge clock) disable iff (rst)
      (q.mode == FOSR_BLOCKED && q.blocked_cnt == 32'd1) |=> (q.mode == FOSR_IDLE);
  endproperty
  a_blocked_end: assert property (p_blocked_end) else $error("blocked erase did not end");

  property p_more_window;
    @(posedge clock) disable iff (rst)
      (avs_wr && avs_address == FOSR_ADDR_EVENT && avs_writedata[FOSR_EV_MORE_BIT]
        && !avs_writedata[FOSR_EV_ERASE_BIT]) |=> !q.window_open;
  endproperty
  a_more_window: assert property (p_more_window) else $error("window stayed open");

  property p_oe_select;
    @(posedge clock) disable iff (rst)
      q.data_oe |-> $past(selected);
  endproperty
  a_oe_select: assert property (p_oe_select) else $error("data driven without select");
endmodule
